// ==== ldsri_pkg.sv ====
package ldsri_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] LDSRI_LINK_LOSS_TIMER_CTL_OFS = 8'h26;
    localparam logic [7:0] LDSRI_SCRATCH_BYTE_A_OFS = 8'h2e;
    localparam logic [7:0] LDSRI_SCRATCH_BYTE_B_OFS = 8'h2f;
    localparam logic [7:0] LDSRI_FAR_IRQ_ROUTE_CTL_OFS = 8'h30;

    localparam logic [2:0] LDSRI_TIMER_SEL_RST = 3'h0;
    localparam logic [7:0] LDSRI_SCRATCH_A_RST = 8'ha5;
    localparam logic [7:0] LDSRI_SCRATCH_B_RST = 8'h5a;
    localparam logic [3:0] LDSRI_PIN_SEL_RST = 4'h0;
    localparam logic [7:0] LDSRI_UNMAPPED_RDATA = 8'h00;

    // field positions
    localparam int LDSRI_TIMER_SEL_LSB = 0;
    localparam int LDSRI_TIMER_SEL_W = 3;
    localparam int LDSRI_PIN_SEL_LSB = 0;
    localparam int LDSRI_PIN_SEL_W = 4;

    // ****************************************
    // route codes
    // ****************************************
    localparam logic [3:0] LDSRI_ROUTE_OFF = 4'h0;
    localparam logic [3:0] LDSRI_ROUTE_SPLIT = 4'h1;

    // ****************************************
    // timing
    // ****************************************
    localparam longint unsigned LDSRI_CLK_KHZ = 64'd25_000;
    // timeouts in nanoseconds, as printed
    localparam longint unsigned LDSRI_T0_NS = 64'd162_000_000;
    localparam longint unsigned LDSRI_T1_NS = 64'd325_000_000;
    localparam longint unsigned LDSRI_T2_NS = 64'd650_000_000;
    localparam longint unsigned LDSRI_T3_NS = 64'd1_300_000;
    localparam longint unsigned LDSRI_T4_NS = 64'd10_250;
    localparam longint unsigned LDSRI_T5_NS = 64'd20_500;
    localparam longint unsigned LDSRI_T6_NS = 64'd41_000;
    localparam longint unsigned LDSRI_T7_NS = 64'd82_000;

    // least time, rounded up to whole cycles
    function automatic logic [31:0] ldsri_ns_to_cyc(input longint unsigned ns);
        longint unsigned c;
        c = (ns * LDSRI_CLK_KHZ + 64'd999_999) / 64'd1_000_000;
        return (c == 64'd0) ? 32'h1 : c[31:0];
    endfunction

    localparam logic [31:0] LDSRI_T0_CYC = ldsri_ns_to_cyc(LDSRI_T0_NS);
    localparam logic [31:0] LDSRI_T1_CYC = ldsri_ns_to_cyc(LDSRI_T1_NS);
    localparam logic [31:0] LDSRI_T2_CYC = ldsri_ns_to_cyc(LDSRI_T2_NS);
    localparam logic [31:0] LDSRI_T3_CYC = ldsri_ns_to_cyc(LDSRI_T3_NS);
    localparam logic [31:0] LDSRI_T4_CYC = ldsri_ns_to_cyc(LDSRI_T4_NS);
    localparam logic [31:0] LDSRI_T5_CYC = ldsri_ns_to_cyc(LDSRI_T5_NS);
    localparam logic [31:0] LDSRI_T6_CYC = ldsri_ns_to_cyc(LDSRI_T6_NS);
    localparam logic [31:0] LDSRI_T7_CYC = ldsri_ns_to_cyc(LDSRI_T7_NS);

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldsri_req_t;

    typedef struct packed {
        logic far_irq;
        logic main_irq;
        logic [3:0] gp;
        logic [3:0] aux_gp;
    } ldsri_pins_t;

endpackage : ldsri_pkg

// ==== ldsri_regs.sv ====
module ldsri_regs
    import ldsri_pkg::*;
#(
    parameter logic [31:0] T0_CYC = LDSRI_T0_CYC,
    parameter logic [31:0] T1_CYC = LDSRI_T1_CYC,
    parameter logic [31:0] T2_CYC = LDSRI_T2_CYC,
    parameter logic [31:0] T3_CYC = LDSRI_T3_CYC
)
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // register port from the serial control bus
    input wire ldsri_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // back channel
    input wire logic bc_valid_i,
    output logic link_detect_o,
    // interrupts
    input wire logic [1:0] far_irq_i,
    input wire logic local_irq_i,
    input wire logic dual_link_i,
    // pin mux
    output ldsri_pins_t pins_o,
    output logic [3:0] gp_sel_o,
    output logic [3:0] aux_gp_sel_o
);

    // ****************************************
    // registers
    // ****************************************
    logic [2:0] timer_sel_reg, timer_sel_next;
    logic [7:0] scratch_a_reg, scratch_a_next;
    logic [7:0] scratch_b_reg, scratch_b_next;
    logic [3:0] pin_sel_reg, pin_sel_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    always_comb
    begin
        timer_sel_next = timer_sel_reg;
        scratch_a_next = scratch_a_reg;
        scratch_b_next = scratch_b_reg;
        pin_sel_next = pin_sel_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (req_i.wr)
        begin
            if (hit(req_i.addr, LDSRI_LINK_LOSS_TIMER_CTL_OFS))
                // upper bits dropped on write
                timer_sel_next = req_i.wdata[LDSRI_TIMER_SEL_LSB +: LDSRI_TIMER_SEL_W];
            if (hit(req_i.addr, LDSRI_SCRATCH_BYTE_A_OFS))
                scratch_a_next = req_i.wdata;
            if (hit(req_i.addr, LDSRI_SCRATCH_BYTE_B_OFS))
                scratch_b_next = req_i.wdata;
            if (hit(req_i.addr, LDSRI_FAR_IRQ_ROUTE_CTL_OFS))
                pin_sel_next = req_i.wdata[LDSRI_PIN_SEL_LSB +: LDSRI_PIN_SEL_W];
        end
        if (req_i.rd)
        begin
            rvalid_next = 1'b1;
            unique case (req_i.addr)
                LDSRI_LINK_LOSS_TIMER_CTL_OFS: rdata_next = {5'h00, timer_sel_reg};
                LDSRI_SCRATCH_BYTE_A_OFS: rdata_next = scratch_a_reg;
                LDSRI_SCRATCH_BYTE_B_OFS: rdata_next = scratch_b_reg;
                LDSRI_FAR_IRQ_ROUTE_CTL_OFS: rdata_next = {4'h0, pin_sel_reg};
                default: rdata_next = LDSRI_UNMAPPED_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            timer_sel_reg <= LDSRI_TIMER_SEL_RST;
            scratch_a_reg <= LDSRI_SCRATCH_A_RST;
            scratch_b_reg <= LDSRI_SCRATCH_B_RST;
            pin_sel_reg <= LDSRI_PIN_SEL_RST;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            timer_sel_reg <= timer_sel_next;
            scratch_a_reg <= scratch_a_next;
            scratch_b_reg <= scratch_b_next;
            pin_sel_reg <= pin_sel_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;

    // ****************************************
    // link-detect timer
    // ****************************************
    logic [31:0] limit;
    logic [31:0] cnt_reg, cnt_next;
    logic detect_reg, detect_next;

    always_comb
    begin
        unique case (timer_sel_reg)
            3'h0: limit = T0_CYC;
            3'h1: limit = T1_CYC;
            3'h2: limit = T2_CYC;
            3'h3: limit = T3_CYC;
            3'h4: limit = LDSRI_T4_CYC;
            3'h5: limit = LDSRI_T5_CYC;
            3'h6: limit = LDSRI_T6_CYC;
            3'h7: limit = LDSRI_T7_CYC;
        endcase
    end

    // compare with >= so a shorter code chosen mid-count expires at once
    always_comb
    begin
        cnt_next = cnt_reg;
        detect_next = detect_reg;
        if (bc_valid_i)
        begin
            cnt_next = 32'h0;
            detect_next = 1'b1;
        end
        else if (detect_reg)
        begin
            if (cnt_reg + 32'h1 >= limit)
            begin
                detect_next = 1'b0;
                cnt_next = 32'h0;
            end
            else
                cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cnt_reg <= 32'h0;
            detect_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_reg <= cnt_next;
            detect_reg <= detect_next;
        end
    end

    assign link_detect_o = detect_reg;

    // ****************************************
    // remote interrupt routing
    // ****************************************
    ldsri_pins_t pins_reg, pins_next;
    logic [3:0] gp_sel_reg, gp_sel_next;
    logic [3:0] aux_sel_reg, aux_sel_next;
    logic far_comb;

    always_comb
    begin
        // dual-link carries one remote interrupt on port 0
        far_comb = dual_link_i ? far_irq_i[0] : (far_irq_i[0] | far_irq_i[1]);
        pins_next = '0;
        gp_sel_next = 4'h0;
        aux_sel_next = 4'h0;
        pins_next.main_irq = local_irq_i;
        if (pin_sel_reg == LDSRI_ROUTE_SPLIT)
        begin
            pins_next.far_irq = far_irq_i[0];
            pins_next.main_irq = local_irq_i | far_irq_i[1];
        end
        else if (pin_sel_reg[3])
        begin
            // reserved codes 0010-0111 never reach this branch and stay disabled
            if (pin_sel_reg[2])
            begin
                aux_sel_next[pin_sel_reg[1:0]] = 1'b1;
                pins_next.aux_gp[pin_sel_reg[1:0]] = far_comb;
            end
            else
            begin
                gp_sel_next[pin_sel_reg[1:0]] = 1'b1;
                pins_next.gp[pin_sel_reg[1:0]] = far_comb;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pins_reg <= '0;
            gp_sel_reg <= 4'h0;
            aux_sel_reg <= 4'h0;
        end
        else if (ce_i)
        begin
            pins_reg <= pins_next;
            gp_sel_reg <= gp_sel_next;
            aux_sel_reg <= aux_sel_next;
        end
    end

    assign pins_o = pins_reg;
    assign gp_sel_o = gp_sel_reg;
    assign aux_gp_sel_o = aux_sel_reg;

endmodule // ldsri_regs

// ==== ldsri_regs_properties.sv ====
module ldsri_regs_props
    import ldsri_pkg::*;
(
    // clock, reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire logic ce_i,
    input wire ldsri_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    // link and pins
    input wire logic bc_valid_i,
    input wire logic link_detect_o,
    input wire ldsri_pins_t pins_o,
    input wire logic [3:0] gp_sel_o,
    input wire logic [3:0] aux_gp_sel_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_wr_a;
        ce_i && req_i.wr && req_i.addr == 8'h2e;
    endsequence
    sequence s_rd_a;
        ce_i && req_i.rd && !req_i.wr && req_i.addr == 8'h2e;
    endsequence
    a_read_valid: assert property (ce_i && req_i.rd |=> rvalid_o)
        else $error("read not answered");
    // a frozen cycle holds rvalid, so only running cycles must clear it
    a_no_stray: assert property (ce_i && !req_i.rd |=> !rvalid_o)
        else $error("stray rvalid");
    a_scratch_echo: assert property (s_wr_a ##1 s_rd_a |=> rdata_o == $past(req_i.wdata, 2))
        else $error("scratch byte lost");
    a_timer_upper: assert property (rvalid_o && $past(req_i.addr) == 8'h26 |-> rdata_o[7:3] == 5'h00)
        else $error("timer upper bits set");
    a_route_upper: assert property (rvalid_o && $past(req_i.addr) == 8'h30 |-> rdata_o[7:4] == 4'h0)
        else $error("route upper bits set");
    a_link_rise: assert property (ce_i && bc_valid_i |=> link_detect_o)
        else $error("traffic did not raise link");
    a_fall_quiet: assert property ($fell(link_detect_o) |-> !$past(bc_valid_i))
        else $error("link fell after traffic");
    a_pin_onehot: assert property ($onehot0({gp_sel_o, aux_gp_sel_o}))
        else $error("two pins selected");
    a_gp_idle: assert property (gp_sel_o == 4'h0 |-> pins_o.gp == 4'h0)
        else $error("gp driven unselected");
endmodule // ldsri_regs_props

bind ldsri_regs ldsri_regs_props i_props (.clk_sys_i, .reset_i, .ce_i, .req_i, .rdata_o, .rvalid_o,
    .bc_valid_i, .link_detect_o, .pins_o, .gp_sel_o, .aux_gp_sel_o);

// ==== ldsri_far_end.sv ====
// ****************************************
// remote receiver: back-channel pulses, irq levels
// ****************************************
module ldsri_far_end
(
    // clock
    input wire logic clk_sys_i,
    // commands from the bench
    input wire logic send_i,
    input wire logic [1:0] irq_i,
    // back channel
    output logic bc_valid_o = 1'b0,
    output logic [1:0] far_irq_o = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys_i)
    begin
        bc_valid_o <= send_i;
        far_irq_o <= irq_i;
    end
endmodule // ldsri_far_end

// ==== link_detect_scratch_remote_irq_regs_tb.sv ====
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module link_detect_scratch_remote_irq_regs_tb
    import ldsri_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    ldsri_req_t req = '0;
    logic send = 1'b0;
    logic [1:0] irq = 2'h0;
    logic local_irq = 1'b0;
    logic dual = 1'b0;
    logic ce = 1'b1;
    logic bc_valid;
    logic [1:0] far_irq;
    logic [7:0] rdata_o;
    logic rvalid_o;
    logic link_detect_o;
    ldsri_pins_t pins_o;
    logic [3:0] gp_sel_o;
    logic [3:0] aux_gp_sel_o;
    int num_errors = 0;
    int tests_run = 0;
    longint t_rise;
    longint t_fall;
    always #20 clk_sys_i = ~clk_sys_i;
    always @(posedge link_detect_o) t_rise = $time;
    always @(negedge link_detect_o) t_fall = $time;
    // short parameters keep the long timeout codes cheap
    ldsri_regs #(.T0_CYC(32'd20), .T1_CYC(32'd30), .T2_CYC(32'd40), .T3_CYC(32'd50)) i_dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce), .req_i(req), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .bc_valid_i(bc_valid), .link_detect_o(link_detect_o), .far_irq_i(far_irq),
        .local_irq_i(local_irq), .dual_link_i(dual), .pins_o(pins_o), .gp_sel_o(gp_sel_o),
        .aux_gp_sel_o(aux_gp_sel_o));
    ldsri_far_end i_far (.clk_sys_i(clk_sys_i), .send_i(send), .irq_i(irq), .bc_valid_o(bc_valid),
        .far_irq_o(far_irq));
    function automatic longint lim(int c);
        longint t[8] = '{20, 30, 40, 50, 257, 513, 1025, 2050};
        return t[c];
    endfunction
    function automatic logic [17:0] route(logic [3:0] c, logic [1:0] f, logic l, logic d);
        ldsri_pins_t p;
        logic [3:0] g;
        logic [3:0] a;
        logic cb;
        p = '0;
        g = 4'h0;
        a = 4'h0;
        cb = d ? f[0] : |f;
        p.main_irq = l;
        if (c == 4'h1)
        begin
            p.far_irq = f[0];
            p.main_irq = l | f[1];
        end
        else if (c[3])
        begin
            if (c[2])
                p.aux_gp[c[1:0]] = cb;
            else
                p.gp[c[1:0]] = cb;
            if (c[2])
                a[c[1:0]] = 1'b1;
            else
                g[c[1:0]] = 1'b1;
        end
        return {p, g, a};
    endfunction
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        `CHK(rvalid_o, 1'b1)
        `CHK(rdata_o, e)
    endtask
    // two pulses ten cycles apart: the second must restart the count
    task automatic link(int c);
        int i;
        wr(8'h26, 8'(c));
        rd(8'h26, 8'(c));
        @(posedge clk_sys_i);
        send <= 1'b1;
        @(posedge clk_sys_i);
        send <= 1'b0;
        repeat (9) @(posedge clk_sys_i);
        send <= 1'b1;
        @(posedge clk_sys_i);
        send <= 1'b0;
        for (i = 0; i < 2100 && link_detect_o !== 1'b0; i++) @(posedge clk_sys_i);
        #1;
        `CHK((t_fall - t_rise) / 40, 10 + lim(c))
    endtask
    initial
    begin
        logic [7:0] d;
        logic [3:0] cs;
        void'($urandom(32'h1bad));
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(8'h2e, 8'ha5);
        rd(8'h2f, 8'h5a);
        rd(8'h30, 8'h00);
        rd(8'h27, 8'h00);
        wr(8'h26, 8'hff);
        rd(8'h26, 8'h07);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h0f);
        repeat (8)
        begin
            d = 8'($urandom);
            wr(8'h2e, d);
            rd(8'h2e, d);
            wr(8'h2f, ~d);
            rd(8'h2f, ~d);
        end
        // a write offered while frozen must be lost
        @(posedge clk_sys_i);
        ce <= 1'b0;
        wr(8'h2e, ~d);
        @(posedge clk_sys_i);
        req <= '0;
        ce <= 1'b1;
        rd(8'h2e, d);
        // software never writes reserved route codes, legal ones stand in
        for (int c = 0; c < 16; c++)
        begin
            cs = (c >= 2 && c <= 7) ? 4'(c + 6) : 4'(c);
            @(posedge clk_sys_i);
            irq <= 2'($urandom);
            local_irq <= 1'($urandom);
            dual <= 1'($urandom);
            wr(8'h30, 8'(cs));
            rd(8'h30, 8'(cs));
            @(posedge clk_sys_i);
            #1;
            `CHK({pins_o, gp_sel_o, aux_gp_sel_o}, route(cs, far_irq, local_irq, dual))
        end
        for (int c = 0; c < 8; c++)
            link(c);
        summarize();
    end
    initial
    begin
        #1_000_000;
        num_errors++;
        summarize();
    end
endmodule // link_detect_scratch_remote_irq_regs_tb
